// [tpg_top.sv]
// test pattern generator and per-channel digital gain in the sample path
// assumes an AHB-Lite master, one 250 MHz clock, and sample/decimation strobes
// that are already enables on hclk; sync pulses arrive on an asynchronous pin
//
// How it works
// [R01] pattern steps on sample strobe when clock select 0, decimation strobe when 1
// [R02] pattern type 000 (reset) disables generator; converted samples pass
// [R03] every pattern word is built 20 bits wide
// [R04] 16-bit resolution outputs upper 16 pattern bits, dropping four lsbs
// [R05] 32-bit resolution appends 12 zero bits below the pattern
// [R06] type 001 ramps by one per pattern step
// [R07] type 010 ramps by the user pattern value per step
// [R08] type 100 outputs the user pattern value constantly
// [R09] type 101 alternates user value and its inverse
// [R10] type 110 alternates user value and zero
// [R11] software must not use types 011 or 111; here they output zero
// [R12] user pattern value assembled from three byte registers, top nibble masked
// [R13] first channel scaled by 1 plus signed gain over 128
// [R14] second channel scaled likewise by its own gain
// [R15] sync mask: pass all, pass first, gate all, issue pulse on entering 11
// [R16] while a pattern is selected it replaces converted samples
// [R17] ramps wrap modulo two to the twentieth
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tpg_defs.svh"
module tpg_top #(
    parameter int SAMPLE_W = 16
) (
    // clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // ahb-lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // converted samples and rate strobes
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] sample_a,
    input  wire logic [SAMPLE_W-1:0] sample_b,
    input  wire logic                decim_strobe,
    // sync reference pulse pin
    input  wire logic                sync_reference_pulse,
    output logic                     sync_pulse_out,
    // output stream toward the serializer
    output logic                     out_valid,
    input  wire logic                out_ready,
    output tpg_pkg::tpg_sample_t     out_word
);
    // ==========================================================
    // register file
    logic [7:0]  pattern_control_reg;
    logic [7:0]  user_pattern_low_reg;
    logic [7:0]  user_pattern_mid_reg;
    logic [7:0]  user_pattern_high_reg;
    logic [7:0]  first_channel_gain_reg;
    logic [7:0]  second_channel_gain_reg;
    logic [7:0]  sync_mask_control_reg;
    logic [7:0]  output_control_reg;
    logic        wr_pend_reg;
    logic [11:0] wr_idx_reg;
    logic [11:0] rd_idx;
    logic [7:0]  rd_byte;
    logic        addr_phase;

    assign addr_phase = hsel && hready && htrans[1];
    assign rd_idx     = haddr[13:2];
    assign hreadyout  = 1'b1;   // zero wait states
    assign hresp      = 1'b0;   // always okay

    // capture write address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= '0;
        end
        else
        begin
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase)
                wr_idx_reg <= haddr[13:2];
        end
    end

    // register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pattern_control_reg     <= `TPG_RST_PATTERN_CONTROL;
            user_pattern_low_reg    <= `TPG_RST_USER_PATTERN;
            user_pattern_mid_reg    <= `TPG_RST_USER_PATTERN;
            user_pattern_high_reg   <= `TPG_RST_USER_PATTERN;
            first_channel_gain_reg  <= `TPG_RST_GAIN;
            second_channel_gain_reg <= `TPG_RST_GAIN;
            sync_mask_control_reg   <= `TPG_RST_SYNC_MASK;
            output_control_reg      <= `TPG_RST_OUTPUT_CONTROL;
        end
        else if (wr_pend_reg)
        begin
            case (wr_idx_reg)
                `TPG_IDX_PATTERN_CONTROL:     pattern_control_reg     <= hwdata[7:0];
                `TPG_IDX_USER_PATTERN_LOW:    user_pattern_low_reg    <= hwdata[7:0];
                `TPG_IDX_USER_PATTERN_MID:    user_pattern_mid_reg    <= hwdata[7:0];
                `TPG_IDX_USER_PATTERN_HIGH:   user_pattern_high_reg   <= {4'h0, hwdata[3:0]};
                `TPG_IDX_FIRST_CHANNEL_GAIN:  first_channel_gain_reg  <= hwdata[7:0];
                `TPG_IDX_SECOND_CHANNEL_GAIN: second_channel_gain_reg <= hwdata[7:0];
                `TPG_IDX_SYNC_MASK_CONTROL:   sync_mask_control_reg   <= {6'h00, hwdata[1:0]};
                `TPG_IDX_OUTPUT_CONTROL:      output_control_reg      <= {6'h00, hwdata[1:0]};
                default:                      ;
            endcase
        end
    end

    // read mux; unmapped reads return zero
    always_comb
    begin
        case (rd_idx)
            `TPG_IDX_PATTERN_CONTROL:     rd_byte = pattern_control_reg;
            `TPG_IDX_USER_PATTERN_LOW:    rd_byte = user_pattern_low_reg;
            `TPG_IDX_USER_PATTERN_MID:    rd_byte = user_pattern_mid_reg;
            `TPG_IDX_USER_PATTERN_HIGH:   rd_byte = user_pattern_high_reg;
            `TPG_IDX_FIRST_CHANNEL_GAIN:  rd_byte = first_channel_gain_reg;
            `TPG_IDX_SECOND_CHANNEL_GAIN: rd_byte = second_channel_gain_reg;
            `TPG_IDX_SYNC_MASK_CONTROL:   rd_byte = sync_mask_control_reg;
            `TPG_IDX_OUTPUT_CONTROL:      rd_byte = output_control_reg;
            default:                      rd_byte = 8'h00;
        endcase
    end

    // read data registered for the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_phase && !hwrite)
            hrdata <= {24'h00_0000, rd_byte};
    end

    // ==========================================================
    // pattern generator
    tpg_pkg::tpg_pattern_t      pat_type;
    logic [`TPG_PAT_W-1:0]      user_pattern_value;
    logic [`TPG_PAT_W-1:0]      ramp_reg;
    logic                       phase_reg;
    logic [`TPG_PAT_W-1:0]      pat_word;
    logic                       pat_step;
    logic                       pat_on;
    logic                       stall;

    assign pat_type = tpg_pkg::tpg_pattern_t'(pattern_control_reg[`TPG_PAT_TYPE_MSB:0]);
    assign user_pattern_value = {user_pattern_high_reg[3:0], user_pattern_mid_reg,
                                 user_pattern_low_reg};                             // R12
    assign pat_on   = (pat_type != tpg_pkg::TPG_PAT_OFF);                            // R02
    assign pat_step = (pattern_control_reg[`TPG_PAT_CLK_BIT] ? decim_strobe
                                                             : sample_valid) && !stall; // R01

    // ramp accumulator and toggle phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ramp_reg  <= '0;
            phase_reg <= 1'b0;
        end
        else if (!pat_on)
        begin
            ramp_reg  <= '0;
            phase_reg <= 1'b0;
        end
        else if (pat_step)
        begin
            phase_reg <= !phase_reg;
            case (pat_type)
                tpg_pkg::TPG_PAT_RAMP1: ramp_reg <= ramp_reg + 20'h00001;     // R06 R17
                tpg_pkg::TPG_PAT_RAMPU: ramp_reg <= ramp_reg + user_pattern_value; // R07 R17
                default:                ramp_reg <= ramp_reg;
            endcase
        end
    end

    // current 20-bit pattern word
    always_comb
    begin
        case (pat_type)
            tpg_pkg::TPG_PAT_RAMP1,
            tpg_pkg::TPG_PAT_RAMPU:   pat_word = ramp_reg;                          // R03
            tpg_pkg::TPG_PAT_STATIC:  pat_word = user_pattern_value;                // R08
            tpg_pkg::TPG_PAT_TOGINV:  pat_word = phase_reg ? ~user_pattern_value
                                                           : user_pattern_value;    // R09
            tpg_pkg::TPG_PAT_TOGZERO: pat_word = phase_reg ? 20'h00000
                                                           : user_pattern_value;    // R10
            default:                  pat_word = 20'h00000;                         // R11
        endcase
    end

    // ==========================================================
    // digital gain per channel: y = x + x*g/128
    logic [SAMPLE_W-1:0] gained [2];
    logic [SAMPLE_W-1:0] samp   [2];
    logic [7:0]          gain   [2];
    assign samp[0] = sample_a;
    assign samp[1] = sample_b;
    assign gain[0] = first_channel_gain_reg;
    assign gain[1] = second_channel_gain_reg;

    for (genvar ch = 0; ch < 2; ch++)
    begin : g_gain
        logic signed [SAMPLE_W+8:0] prod;
        logic signed [SAMPLE_W+8:0] sum;
        logic signed [SAMPLE_W+8:0] maxv;
        logic signed [SAMPLE_W+8:0] minv;
        // both factors sign-extended to the full product width before multiplying
        assign prod = $signed({{9{samp[ch][SAMPLE_W-1]}}, samp[ch]})
                      * $signed({{(SAMPLE_W+1){gain[ch][7]}}, gain[ch]});            // R13 R14
        assign sum  = ($signed({{9{samp[ch][SAMPLE_W-1]}}, samp[ch]}) <<< `TPG_GAIN_FRAC)
                      + prod;
        assign maxv = (SAMPLE_W+9)'((1 <<< (SAMPLE_W-1)) - 1) <<< `TPG_GAIN_FRAC;
        assign minv = -((SAMPLE_W+9)'(1 <<< (SAMPLE_W-1)) <<< `TPG_GAIN_FRAC);
        // saturate to sample range after dropping the seven fraction bits
        always_comb
        begin
            if (sum > maxv)
                gained[ch] = {1'b0, {(SAMPLE_W-1){1'b1}}};
            else if (sum < minv)
                gained[ch] = {1'b1, {(SAMPLE_W-1){1'b0}}};
            else
                gained[ch] = sum[SAMPLE_W+`TPG_GAIN_FRAC-1:`TPG_GAIN_FRAC];
        end
    end

    // ==========================================================
    // output word formatting and fifo
    tpg_pkg::tpg_sample_t fmt;
    logic                 wide;
    logic                 fill_valid;
    logic                 fill_ready;
    assign wide = output_control_reg[`TPG_OUT_RES_BIT];

    always_comb
    begin
        fmt.wide = wide;
        if (pat_on)
        begin
            // both channels carry the pattern
            fmt.data_a = wide ? {pat_word, 12'h000}                                 // R05
                              : {16'h0000, pat_word[19:4]};                         // R04
            fmt.data_b = fmt.data_a;                                                // R16
        end
        else
        begin
            fmt.data_a = 32'(gained[0]);
            fmt.data_b = 32'(gained[1]);
        end
    end

    assign fill_valid = pat_on ? pat_step : sample_valid;
    assign stall      = !fill_ready;

    tpg_fifo #(
        .WIDTH ($bits(tpg_pkg::tpg_sample_t)),
        .DEPTH (`TPG_FIFO_DEPTH)
    ) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (fill_valid),
        .in_ready  (fill_ready),
        .in_data   (fmt),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_word)
    );

    // ==========================================================
    // sync reference pulse masking
    logic       sync_s1_reg;
    logic       sync_s2_reg;
    logic       sync_s3_reg;
    logic       sync_seen_reg;
    logic [1:0] mode_prev_reg;
    logic       sync_edge;
    tpg_pkg::tpg_sync_mode_t sync_mode;
    assign sync_mode = tpg_pkg::tpg_sync_mode_t'(sync_mask_control_reg[1:0]);
    assign sync_edge = sync_s2_reg && !sync_s3_reg;

    // pin synchroniser and edge history
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync_s1_reg <= 1'b0;
            sync_s2_reg <= 1'b0;
            sync_s3_reg <= 1'b0;
        end
        else
        begin
            sync_s1_reg <= sync_reference_pulse;
            sync_s2_reg <= sync_s1_reg;
            sync_s3_reg <= sync_s2_reg;
        end
    end

    // mask state and output pulse
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync_seen_reg  <= 1'b0;
            mode_prev_reg  <= 2'h0;
            sync_pulse_out <= 1'b0;
        end
        else
        begin
            mode_prev_reg <= sync_mask_control_reg[1:0];
            if (sync_mode != tpg_pkg::TPG_SYNC_FIRST)
                sync_seen_reg <= 1'b0;
            else if (sync_edge)
                sync_seen_reg <= 1'b1;
            case (sync_mode)
                tpg_pkg::TPG_SYNC_PASS:  sync_pulse_out <= sync_edge;                 // R15
                tpg_pkg::TPG_SYNC_FIRST: sync_pulse_out <= sync_edge && !sync_seen_reg; // R15
                tpg_pkg::TPG_SYNC_GATE:  sync_pulse_out <= 1'b0;                      // R15
                tpg_pkg::TPG_SYNC_ISSUE: sync_pulse_out <= (mode_prev_reg != 2'h3);   // R15
                default:                 sync_pulse_out <= 1'b0;
            endcase
        end
    end

    // ==========================================================
    // checks
    sequence s_pat_step;
        pat_on && pat_step && (pat_type == tpg_pkg::TPG_PAT_RAMP1);
    endsequence

    chk_ramp_step_one: assert property (@(posedge hclk) disable iff (!hresetn)   // R06
        s_pat_step ##1 (pat_type == tpg_pkg::TPG_PAT_RAMP1)
        |-> ramp_reg == $past(ramp_reg) + 20'h00001) else $error("ramp step not one");
    chk_ramp_step_user: assert property (@(posedge hclk) disable iff (!hresetn)  // R07
        pat_step && pat_type == tpg_pkg::TPG_PAT_RAMPU ##1 pat_type == tpg_pkg::TPG_PAT_RAMPU
        |-> ramp_reg == $past(ramp_reg) + $past(user_pattern_value))
        else $error("ramp step not user value");
    chk_off_passes: assert property (@(posedge hclk) disable iff (!hresetn)      // R02
        !pat_on |-> fmt.data_a == 32'(gained[0])) else $error("disabled still patterns");
    chk_narrow_trunc: assert property (@(posedge hclk) disable iff (!hresetn)    // R04
        pat_on && !wide |-> fmt.data_a[15:0] == pat_word[19:4])
        else $error("narrow word wrong");
    chk_wide_pad: assert property (@(posedge hclk) disable iff (!hresetn)        // R05
        pat_on && wide |-> fmt.data_a[11:0] == 12'h000 && fmt.data_a[31:12] == pat_word)
        else $error("wide word wrong");
    chk_static_word: assert property (@(posedge hclk) disable iff (!hresetn)     // R08
        pat_type == tpg_pkg::TPG_PAT_STATIC |-> pat_word == user_pattern_value)
        else $error("static word wrong");
    chk_toggle_inv: assert property (@(posedge hclk) disable iff (!hresetn)      // R09
        pat_type == tpg_pkg::TPG_PAT_TOGINV && pat_step ##1
        pat_type == tpg_pkg::TPG_PAT_TOGINV && $stable(user_pattern_value)
        |-> pat_word == ~$past(pat_word)) else $error("toggle not inverting");
    sequence s_zero_step;
        pat_type == tpg_pkg::TPG_PAT_TOGZERO && pat_step && !phase_reg;
    endsequence

    chk_toggle_zero: assert property (@(posedge hclk) disable iff (!hresetn)     // R10
        s_zero_step ##1 pat_type == tpg_pkg::TPG_PAT_TOGZERO |-> pat_word == 20'h00000)
        else $error("toggle zero wrong");
    chk_sync_gate: assert property (@(posedge hclk) disable iff (!hresetn)       // R15
        sync_mode == tpg_pkg::TPG_SYNC_GATE ##1 sync_mode == tpg_pkg::TPG_SYNC_GATE
        |-> !sync_pulse_out) else $error("gated sync pulse leaked");
endmodule

// [tpg_defs.svh]
// register offsets, field positions and reset values of the pattern and gain block
// assumes inclusion by bare name from the package and design files
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH
// register indices (byte address is four times the index)
`define TPG_IDX_PATTERN_CONTROL     12'h14a
`define TPG_IDX_USER_PATTERN_LOW    12'h14b
`define TPG_IDX_USER_PATTERN_MID    12'h14c
`define TPG_IDX_USER_PATTERN_HIGH   12'h14d
`define TPG_IDX_FIRST_CHANNEL_GAIN  12'h15b
`define TPG_IDX_SECOND_CHANNEL_GAIN 12'h15c
`define TPG_IDX_SYNC_MASK_CONTROL   12'h160
`define TPG_IDX_OUTPUT_CONTROL      12'h162
// field positions
`define TPG_PAT_TYPE_LSB            0
`define TPG_PAT_TYPE_MSB            2
`define TPG_PAT_CLK_BIT             4
`define TPG_OUT_RES_BIT             1
`define TPG_SYNC_MODE_MSB           1
// reset values
`define TPG_RST_PATTERN_CONTROL     8'h00
`define TPG_RST_USER_PATTERN        8'h00
`define TPG_RST_GAIN                8'h00
`define TPG_RST_SYNC_MASK           8'h00
`define TPG_RST_OUTPUT_CONTROL      8'h00
// widths and fifo depth
`define TPG_PAT_W                   20
`define TPG_GAIN_FRAC               7
`define TPG_FIFO_DEPTH              8
`endif

// [tpg_pkg.sv]
// types shared by the pattern and gain block
// assumes tpg_defs.svh sits in the same folder
`include "tpg_defs.svh"
package tpg_pkg;
    typedef enum logic [2:0] {
        TPG_PAT_OFF     = 3'h0,
        TPG_PAT_RAMP1   = 3'h1,
        TPG_PAT_RAMPU   = 3'h2,
        TPG_PAT_UNUSED3 = 3'h3,
        TPG_PAT_STATIC  = 3'h4,
        TPG_PAT_TOGINV  = 3'h5,
        TPG_PAT_TOGZERO = 3'h6,
        TPG_PAT_UNUSED7 = 3'h7
    } tpg_pattern_t;
    typedef enum logic [1:0] {
        TPG_SYNC_PASS  = 2'h0,
        TPG_SYNC_FIRST = 2'h1,
        TPG_SYNC_GATE  = 2'h2,
        TPG_SYNC_ISSUE = 2'h3
    } tpg_sync_mode_t;
    // one output sample word with its resolution flag
    typedef struct packed {
        logic        wide;
        logic [31:0] data_a;
        logic [31:0] data_b;
    } tpg_sample_t;
endpackage

// [tpg_fifo.sv]
// parameterised valid/ready FIFO for output sample words
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module tpg_fifo #(
    parameter int WIDTH = 65,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // ==========================================================
    // handshake
    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_reg];

    // storage write
    always_ff @(posedge hclk)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end

    // pointers and occupancy
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_no_overflow: assert property (@(posedge hclk) disable iff (!hresetn)
        count_reg <= (AW+1)'(DEPTH)) else $error("fifo occupancy above depth");
endmodule

// [tpg_sink.sv]
// serializer-side sink model for the pattern and gain output stream
// assumes the tpg_top valid/ready stream on hclk
`timescale 1ns/1ps
module tpg_sink (
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // stream from the block
    input  wire logic                 out_valid,
    output logic                      out_ready,
    input  wire tpg_pkg::tpg_sample_t out_word,
    // back-pressure request from the bench
    input  wire logic                 stall
);
    tpg_pkg::tpg_sample_t q[$];
    // ready follows stall one edge late, like a real serializer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            out_ready <= 1'b0;
        else
            out_ready <= !stall;
    end
    // keep every accepted word
    always @(posedge hclk)
    begin
        if (hresetn && out_valid && out_ready)
            q.push_back(out_word);
    end
endmodule

// [test_tpg_top.sv]
// self-checking bench of the pattern and gain block
// assumes tpg_pkg, tpg_fifo, tpg_top and tpg_sink compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module test_tpg_top;
    typedef struct {logic [11:0] ix; logic [7:0] wd; logic [7:0] rd;} tpg_reg_row_t;
    typedef struct {logic [2:0] ty; logic [19:0] v; logic wd; logic sel;} tpg_pat_row_t;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, stall = 0;
    logic        sample_valid = 0, decim_strobe = 0, sync_reference_pulse = 0;
    logic [15:0] sample_a = 16'h0100, sample_b = 16'h0100;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0]  htrans = 0;
    logic        hreadyout, hresp, sync_pulse_out, out_valid, out_ready;
    logic [7:0]  r;
    logic [19:0] p0, e0, e1, alt;
    int          error_cnt = 0, n_checks = 0, pulses = 0, base;
    tpg_pkg::tpg_sample_t out_word, w0, w1;
    tpg_reg_row_t rg [9] = '{'{12'h14b, 8'ha5, 8'ha5}, '{12'h14c, 8'h5a, 8'h5a},
        '{12'h14d, 8'hff, 8'h0f}, '{12'h15b, 8'h80, 8'h80}, '{12'h15c, 8'h7f, 8'h7f},
        '{12'h160, 8'h02, 8'h02}, '{12'h162, 8'h02, 8'h02}, '{12'h14a, 8'h10, 8'h10},
        '{12'h100, 8'hff, 8'h00}};
    tpg_pat_row_t pr [7] = '{'{3'h4, 20'h12345, 0, 0}, '{3'h4, 20'h6789a, 1, 1},
        '{3'h1, 20'h0, 1, 0}, '{3'h2, 20'h00010, 0, 1}, '{3'h2, 20'hfffff, 1, 0},
        '{3'h5, 20'ha5a5a, 1, 0}, '{3'h6, 20'h5a5a5, 1, 1}};
    // ====================================================
    // design, sink and clock
    tpg_top tpg_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sample_valid,
        .sample_a, .sample_b, .decim_strobe, .sync_reference_pulse,
        .sync_pulse_out, .out_valid, .out_ready, .out_word);
    tpg_sink tpg_sink_i (.hclk, .hresetn, .out_valid, .out_ready, .out_word, .stall);
    initial
    begin
        forever #2 hclk = ~hclk;
    end
    // count masked sync pulses
    always @(posedge hclk)
    begin
        if (sync_pulse_out === 1'b1)
            pulses <= pulses + 1;
    end
    // ====================================================
    // tasks
    task automatic bus(input logic [11:0] ix, input logic w, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {18'h0, ix, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata[7:0];
    endtask
    // one strobe: decimation if s, else sample
    task automatic step(input logic s);
        @(posedge hclk);
        sample_valid <= !s;
        decim_strobe <= s;
        @(posedge hclk);
        sample_valid <= 1'b0;
        decim_strobe <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
    task automatic pin;
        @(posedge hclk);
        sync_reference_pulse <= 1'b1;
        repeat (4) @(posedge hclk);
        sync_reference_pulse <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask
    function automatic logic [31:0] fmt(input logic [19:0] p, input logic wd);
        return wd ? {p, 12'h0} : {16'h0, p[19:4]};
    endfunction
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #100000;
        error_cnt++;
        summarize();
    end
    // ====================================================
    // main sequence
    initial
    begin
        repeat (6) @(posedge hclk);
        `CHK({out_valid, sync_pulse_out, hreadyout, hresp}, 4'b0010)
        hresetn <= 1'b1;
        foreach (rg[i])
        begin
            bus(rg[i].ix, 1'b0, 8'h00);
            `CHK(r, 8'h00)
        end
        foreach (rg[i])
        begin
            bus(rg[i].ix, 1'b1, rg[i].wd);
            bus(rg[i].ix, 1'b0, 8'h00);
            `CHK(r, rg[i].rd)
        end
        foreach (pr[i])
        begin
            bus(12'h14b, 1'b1, pr[i].v[7:0]);
            bus(12'h14c, 1'b1, pr[i].v[15:8]);
            bus(12'h14d, 1'b1, {4'h0, pr[i].v[19:16]});
            bus(12'h162, 1'b1, {6'h0, pr[i].wd, 1'b0});
            bus(12'h14a, 1'b1, {3'h0, pr[i].sel, 1'b0, pr[i].ty});
            base = tpg_sink_i.q.size();
            step(!pr[i].sel);
            `CHK(tpg_sink_i.q.size() - base, 0)
            step(pr[i].sel);
            step(pr[i].sel);
            w0 = tpg_sink_i.q[base];
            w1 = tpg_sink_i.q[base + 1];
            p0 = pr[i].wd ? w0.data_a[31:12] : {w0.data_a[15:0], 4'h0};
            alt = (pr[i].ty == 3'h5) ? ~pr[i].v : (pr[i].ty == 3'h6) ? 20'h0 : pr[i].v;
            e0 = pr[i].ty[2] ? ((p0 === alt) ? alt : pr[i].v) : p0;
            case (pr[i].ty)
                3'h1: e1 = p0 + 20'h1;
                3'h2: e1 = p0 + pr[i].v;
                3'h5: e1 = ~e0;
                3'h6: e1 = (e0 === 20'h0) ? pr[i].v : 20'h0;
                default: e1 = pr[i].v;
            endcase
            `CHK(w0.data_a, fmt(e0, pr[i].wd))
            `CHK(w1.data_a, fmt(e1, pr[i].wd))
            `CHK({w1.wide, w1.data_b}, {pr[i].wd, w1.data_a})
        end
        bus(12'h14a, 1'b1, 8'h00);
        bus(12'h162, 1'b1, 8'h00);
        bus(12'h15b, 1'b1, 8'h40);
        bus(12'h15c, 1'b1, 8'hc0);
        stall <= 1'b1;
        base = tpg_sink_i.q.size();
        repeat (10) step(1'b0);
        `CHK({out_valid, tpg_sink_i.q.size() == base}, 2'b11)
        stall <= 1'b0;
        repeat (20) @(posedge hclk);
        `CHK(tpg_sink_i.q.size() - base, 8)
        w0 = tpg_sink_i.q[base];
        `CHK({w0.wide, w0.data_a, w0.data_b}, {1'b0, 32'h180, 32'h80})
        // near-doubling of a large sample saturates; -1 cancels a negative sample
        sample_a <= 16'h7000;
        sample_b <= 16'hff00;
        bus(12'h15b, 1'b1, 8'h7f);
        bus(12'h15c, 1'b1, 8'h80);
        base = tpg_sink_i.q.size();
        step(1'b0);
        w0 = tpg_sink_i.q[base];
        `CHK({w0.data_a, w0.data_b}, {32'h7fff, 32'h0})
        for (int m = 0; m < 3; m++)
        begin
            bus(12'h160, 1'b1, m[7:0]);
            pulses = 0;
            pin();
            pin();
            `CHK(pulses, 2 - m)
        end
        pulses = 0;
        bus(12'h160, 1'b1, 8'h03);
        repeat (4) @(posedge hclk);
        `CHK(pulses, 1)
        // reset in mid-run: every register back to zero, no stray sync pulse
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        pulses = 0;
        foreach (rg[i])
        begin
            bus(rg[i].ix, 1'b0, 8'h00);
            `CHK(r, 8'h00)
        end
        `CHK({out_valid, pulses == 0}, 2'b01)
        summarize();
    end
endmodule
